// *** logic/acdp_core.sv ***
// ac diagnostic sequencing, channel protection and i2c register file

module acdp_core #(
	parameter logic [6:0] DEV_ADDR = 7'h5C // arbitrary default
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	// control bus pins
	input  wire logic                  scl_pin,
	input  wire logic                  sda_pin_in,
	output logic                       sda_pin_out,
	output logic                       sda_pin_oe,
	// status pins, open drain
	output logic                       fault_pin_out,
	output logic                       fault_pin_oe,
	output logic                       warn_pin_out,
	output logic                       warn_pin_oe,
	// analog comparators
	input  acdp_pkg::acdp_ana_t        ana_in,
	// modulator
	input  wire logic [3:0]            pwm_in,
	input  wire logic                  pwm_tick,
	input  wire logic [3:0]            full_duty,
	output logic [3:0]                 pwm_out,
	// ac measurement engine
	input  acdp_pkg::acdp_ac_res_t     ac_res,
	output logic [1:0]                 ac_loop_run,
	output logic                       ac_loopback_select,
	// dc diagnostic engine
	input  wire logic [3:0]            diag_done,
	input  wire logic [3:0]            load_fault,
	output logic [3:0]                 dc_diag_run,
	// configuration out
	output logic [1:0]                 paired_bridge_mode,
	output logic                       ilimit_level,
	output logic [3:0]                 chan_hiz
);

	initial begin
		if (DEV_ADDR == 7'h00) begin
			$error("device address zero is the general call");
		end
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [acdp_pkg::NSYNC-1:0]        sync1;
		logic [acdp_pkg::NSYNC-1:0]        sync2;
		logic                              scl_p;
		logic                              sda_p;
		acdp_pkg::acdp_i2c_t               i2;
		logic [3:0]                        bitcnt;
		logic [7:0]                        shreg;
		logic [7:0]                        ptr;
		logic                              sda_oe;
		logic [1:0]                        bridge;
		logic                              ilim;
		logic [1:0]                        ac_en;
		logic                              loopback;
		logic                              dc_mask;
		logic                              clip_mask;
		logic                              diag_en;
		logic [7:0]                        clip_win;
		logic [15:0]                       phase;
		logic [15:0]                       stim;
		logic [1:0]                        ac_busy;
		acdp_pkg::acdp_ch_t [3:0]          ch;
		logic [3:0]                        oc_flt;
		logic [3:0]                        dc_flt;
		logic                              clip;
		logic [3:0][7:0]                   clip_cnt;
		logic [3:0]                        trip;
		logic [3:0]                        pwm_out;
		logic                              fault_oe;
		logic                              warn_oe;
	} acdp_st_t;

	acdp_st_t            st_q;
	acdp_st_t            st_d;
	logic                rst_meta_n;
	logic                rst_n;
	acdp_pkg::acdp_ana_t ana_s;
	logic                scl_s;
	logic                sda_s;
	logic                clr;
	logic                clip_evt;
	logic                ac_fin;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	assign ana_s = st_q.sync2[11:0];
	assign scl_s = st_q.sync2[13];
	assign sda_s = st_q.sync2[12];

	function automatic logic [1:0] ch_code(input acdp_pkg::acdp_ch_t c);
		logic [1:0] r;
		r = acdp_pkg::CODE_HIZ;
		if (c == acdp_pkg::CH_PLAY) r = acdp_pkg::CODE_PLAY;
		if (c == acdp_pkg::CH_AC) r = acdp_pkg::CODE_AC;
		if (c == acdp_pkg::CH_DC) r = acdp_pkg::CODE_DC;
		return r;
	endfunction

	// reserved bits and unmapped offsets read zero
	function automatic logic [7:0] reg_rd(input acdp_st_t s, input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			acdp_pkg::REG_BRIDGE:   r[1:0] = s.bridge;
			acdp_pkg::REG_MISC1:    r[acdp_pkg::BIT_ILIM_LVL] = s.ilim;
			acdp_pkg::REG_CH_STATE: r = {ch_code(s.ch[3]), ch_code(s.ch[2]), ch_code(s.ch[1]), ch_code(s.ch[0])};
			acdp_pkg::REG_FAULT:    r = {s.dc_flt, s.oc_flt};
			acdp_pkg::REG_WARN:     r[0] = s.clip;
			acdp_pkg::REG_AC_EN:    r = {4'h0, s.ac_en[0], 1'b0, s.ac_en[1], 1'b0};
			acdp_pkg::REG_AC_CFG:   r[acdp_pkg::BIT_LOOPBACK] = s.loopback;
			acdp_pkg::REG_PH_HI:    r = s.phase[15:8];
			acdp_pkg::REG_PH_LO:    r = s.phase[7:0];
			acdp_pkg::REG_STI_HI:   r = s.stim[15:8];
			acdp_pkg::REG_STI_LO:   r = s.stim[7:0];
			acdp_pkg::REG_MISC3:    r = {5'h00, s.diag_en, s.clip_mask, s.dc_mask};
			acdp_pkg::REG_CLIP_WIN: r = s.clip_win;
			default:                r = 8'h00;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic       wr;
		logic       start;
		logic       stop;
		logic       rise;
		logic       fall;
		logic [1:0] en_new;
		logic       ev;
		st_d     = st_q;
		wr       = 1'b0;
		clr      = 1'b0;
		clip_evt = 1'b0;
		ac_fin   = 1'b0;
		en_new   = st_q.ac_en;
		ev       = 1'b0;
		st_d.sync1 = {scl_pin, sda_pin_in, ana_in};
		st_d.sync2 = st_q.sync1;
		st_d.scl_p = scl_s;
		st_d.sda_p = sda_s;
		start = scl_s && st_q.scl_p && st_q.sda_p && !sda_s;
		stop  = scl_s && st_q.scl_p && !st_q.sda_p && sda_s;
		rise  = scl_s && !st_q.scl_p;
		fall  = !scl_s && st_q.scl_p;

		// control bus slave, auto-incrementing pointer
		if (start) begin
			st_d.i2     = acdp_pkg::I2_DEV;
			st_d.bitcnt = 4'h0;
			st_d.sda_oe = 1'b0;
		end else if (stop) begin
			st_d.i2     = acdp_pkg::I2_IDLE;
			st_d.sda_oe = 1'b0;
		end else if (st_q.i2 != acdp_pkg::I2_IDLE) begin
			if (rise && st_q.bitcnt < 4'h8) begin
				st_d.shreg  = {st_q.shreg[6:0], sda_s};
				st_d.bitcnt = st_q.bitcnt + 4'h1;
			end else if (rise && st_q.bitcnt == 4'h8 && st_q.i2 == acdp_pkg::I2_RD) begin
				if (sda_s) begin
					st_d.i2 = acdp_pkg::I2_IDLE;
				end else begin
					st_d.ptr    = st_q.ptr + 8'h01;
					st_d.shreg  = reg_rd(st_q, st_q.ptr + 8'h01);
					st_d.bitcnt = 4'h9;
				end
			end else if (fall && st_q.bitcnt < 4'h8) begin
				st_d.sda_oe = (st_q.i2 == acdp_pkg::I2_RD) && !st_q.shreg[7];
			end else if (fall && st_q.bitcnt == 4'h8) begin
				st_d.sda_oe = st_q.i2 != acdp_pkg::I2_RD;
				st_d.bitcnt = (st_q.i2 == acdp_pkg::I2_RD) ? 4'h8 : 4'h9;
				unique case (st_q.i2)
					acdp_pkg::I2_DEV: begin
						if (st_q.shreg[7:1] != DEV_ADDR) begin
							st_d.i2     = acdp_pkg::I2_IDLE;
							st_d.sda_oe = 1'b0;
						end else if (st_q.shreg[0]) begin
							st_d.i2    = acdp_pkg::I2_RD;
							st_d.shreg = reg_rd(st_q, st_q.ptr);
						end else begin
							st_d.i2 = acdp_pkg::I2_PTR;
						end
					end
					acdp_pkg::I2_PTR: begin
						st_d.ptr = st_q.shreg;
						st_d.i2  = acdp_pkg::I2_WR;
					end
					acdp_pkg::I2_WR: begin
						wr       = 1'b1;
						st_d.ptr = st_q.ptr + 8'h01;
					end
					acdp_pkg::I2_RD: begin
						st_d.sda_oe = 1'b0;
					end
					default: begin
						st_d.i2 = acdp_pkg::I2_IDLE;
					end
				endcase
			end else if (fall && st_q.bitcnt == 4'h9) begin
				st_d.bitcnt = 4'h0;
				st_d.sda_oe = (st_q.i2 == acdp_pkg::I2_RD) && !st_q.shreg[7];
			end
		end

		// register writes
		if (wr) begin
			case (st_q.ptr)
				acdp_pkg::REG_BRIDGE:   st_d.bridge = st_q.shreg[1:0];
				acdp_pkg::REG_MISC1:    st_d.ilim = st_q.shreg[acdp_pkg::BIT_ILIM_LVL];
				acdp_pkg::REG_AC_EN:    en_new = {st_q.shreg[acdp_pkg::BIT_AC_LOOP3], st_q.shreg[acdp_pkg::BIT_AC_LOOP1]};
				acdp_pkg::REG_AC_CFG:   st_d.loopback = st_q.shreg[acdp_pkg::BIT_LOOPBACK];
				acdp_pkg::REG_MISC3: begin
					clr            = st_q.shreg[acdp_pkg::BIT_CLEAR_FAULT];
					st_d.dc_mask   = st_q.shreg[acdp_pkg::BIT_DC_MASK];
					st_d.clip_mask = st_q.shreg[acdp_pkg::BIT_CLIP_MASK];
					st_d.diag_en   = st_q.shreg[acdp_pkg::BIT_DIAG_EN];
				end
				acdp_pkg::REG_CLIP_WIN: st_d.clip_win = st_q.shreg;
				default:                st_d.ptr = st_q.ptr + 8'h01;
			endcase
		end

		// ac measurement; a start while a loop runs is ignored, but two starts in one write both run
		st_d.ac_en = en_new;
		for (int k = 0; k < 2; k++) begin
			if (en_new[k] && !st_q.ac_en[k] && st_q.ac_busy == 2'b00) begin
				st_d.ac_busy[k] = 1'b1;
				for (int j = 0; j < 2; j++) begin
					if (st_q.ch[2*k+j] == acdp_pkg::CH_HIZ || st_q.ch[2*k+j] == acdp_pkg::CH_PLAY) begin
						st_d.ch[2*k+j] = acdp_pkg::CH_AC;
					end
				end
			end else if (!en_new[k] && st_q.ac_en[k]) begin
				st_d.ac_busy[k] = 1'b0;
				for (int j = 0; j < 2; j++) begin
					if (st_q.ch[2*k+j] == acdp_pkg::CH_AC || st_q.ch[2*k+j] == acdp_pkg::CH_HIZ) begin
						if (!st_q.oc_flt[2*k+j] && !st_q.dc_flt[2*k+j]) st_d.ch[2*k+j] = acdp_pkg::CH_PLAY;
					end
				end
			end else if (st_q.ac_busy[k] && ac_res.done) begin
				ac_fin          = 1'b1;
				st_d.ac_busy[k] = 1'b0;
				st_d.phase      = ac_res.phase;
				if (!st_q.loopback) st_d.stim = ac_res.stim;
				for (int j = 0; j < 2; j++) begin
					if (st_q.ch[2*k+j] == acdp_pkg::CH_AC) st_d.ch[2*k+j] = acdp_pkg::CH_HIZ;
				end
			end
		end

		// per-channel protection
		for (int i = 0; i < acdp_pkg::NCH; i++) begin
			// pulse cut lasts to end of the pwm pulse, no fault raised
			st_d.trip[i] = pwm_in[i] && (st_q.trip[i] || ana_s.lim[i]);
			if (clr && (st_q.oc_flt[i] || st_q.dc_flt[i])) begin
				st_d.oc_flt[i] = 1'b0;
				st_d.dc_flt[i] = 1'b0;
				st_d.ch[i] = st_q.diag_en ? acdp_pkg::CH_DC : acdp_pkg::CH_PLAY;
			end else if (st_q.ch[i] == acdp_pkg::CH_DC && diag_done[i] && !load_fault[i]) begin
				st_d.ch[i] = acdp_pkg::CH_PLAY;
			end
			// an overcurrent event wins over a clear in the same cycle; a dc event only latches on a channel already playing
			if (ana_s.sd[i]) begin
				st_d.oc_flt[i] = 1'b1;
				st_d.ch[i]     = acdp_pkg::CH_HIZ;
			end
			if (ana_s.dc[i] && st_q.ch[i] == acdp_pkg::CH_PLAY) begin
				st_d.dc_flt[i] = 1'b1;
				st_d.ch[i]     = acdp_pkg::CH_HIZ;
			end
			st_d.pwm_out[i] = pwm_in[i] && !st_d.trip[i] && st_d.ch[i] == acdp_pkg::CH_PLAY;
			// consecutive full-duty cycle count
			if (pwm_tick) begin
				if (!full_duty[i]) begin
					st_d.clip_cnt[i] = 8'h00;
				end else if (st_q.clip_cnt[i] != st_q.clip_win) begin
					st_d.clip_cnt[i] = st_q.clip_cnt[i] + 8'h01;
				end
				if (full_duty[i] && st_d.clip_cnt[i] == st_q.clip_win && st_q.clip_win != 8'h00) begin
					ev = 1'b1;
				end
			end
		end
		clip_evt     = ev;
		st_d.clip    = (st_q.clip && !clr) || ev;
		st_d.warn_oe = st_d.clip && !st_d.clip_mask;
		st_d.fault_oe = (|st_d.oc_flt) || (|(st_d.dc_flt & {4{!st_d.dc_mask}}));
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q          <= '0;
			// bus pins idle high, comparators idle low: no false fault after reset
			st_q.sync1    <= {2'b11, {(acdp_pkg::NSYNC-2){1'b0}}};
			st_q.sync2    <= {2'b11, {(acdp_pkg::NSYNC-2){1'b0}}};
			st_q.scl_p    <= 1'b1;
			st_q.sda_p    <= 1'b1;
			st_q.i2       <= acdp_pkg::I2_IDLE;
			st_q.diag_en  <= acdp_pkg::RST_DIAG_EN;
			st_q.clip_win <= acdp_pkg::RST_CLIP_WIN;
			st_q.ch       <= {acdp_pkg::NCH{acdp_pkg::CH_PLAY}};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign sda_pin_out        = 1'b0;
	assign sda_pin_oe         = st_q.sda_oe;
	assign fault_pin_out      = 1'b0;
	assign fault_pin_oe       = st_q.fault_oe;
	assign warn_pin_out       = 1'b0;
	assign warn_pin_oe        = st_q.warn_oe;
	assign pwm_out            = st_q.pwm_out;
	assign ac_loop_run        = st_q.ac_busy;
	assign ac_loopback_select = st_q.loopback;
	assign paired_bridge_mode = st_q.bridge;
	assign ilimit_level       = st_q.ilim;

	generate
		for (genvar g = 0; g < acdp_pkg::NCH; g++) begin : g_ch
			assign dc_diag_run[g] = st_q.ch[g] == acdp_pkg::CH_DC;
			assign chan_hiz[g]    = st_q.ch[g] != acdp_pkg::CH_PLAY;
		end
	endgenerate

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_oc_shuts_down: assert property (@(posedge core_clk) disable iff (!rst_n)
		ana_s.sd[2] |=> chan_hiz[2] && !pwm_out[2] && fault_pin_oe && st_q.oc_flt[2])
		else $error("overcurrent did not shut channel 2 down");
	a_limit_cuts_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		ana_s.lim[1] |=> !pwm_out[1])
		else $error("current limit did not cut the pulse");
	a_limit_no_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
		(st_q.oc_flt == 4'h0 && st_q.dc_flt == 4'h0 && ana_s.sd == 4'h0 && ana_s.dc == 4'h0) |=> !fault_pin_oe)
		else $error("fault pin without a fault");
	a_clear_releases: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clr && !clip_evt) |=> !warn_pin_oe ##0 !st_q.clip)
		else $error("fault clear left the warn latch set");
	a_clear_restarts: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clr && st_q.oc_flt[2] && st_q.diag_en && !ana_s.sd[2] && !ana_s.dc[2]) |=> dc_diag_run[2] && !st_q.oc_flt[2])
		else $error("clear did not start rediagnosis");
	a_ac_result_store: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ac_fin && st_q.ac_busy[0] && st_q.ch[0] == acdp_pkg::CH_AC && !ana_s.sd[0])
		|=> st_q.ch[0] == acdp_pkg::CH_HIZ && ac_loop_run == 2'b00 && st_q.phase == $past(ac_res.phase))
		else $error("ac result not stored on finish");
	a_ref_keeps_stim: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ac_fin && ac_loopback_select) |=> $stable(st_q.stim))
		else $error("reference stage overwrote stimulus count");
	a_clip_to_warn: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clip_evt && !st_d.clip_mask) |=> warn_pin_oe ##1 (warn_pin_oe || $past(clr) || st_q.clip_mask))
		else $error("clip not reported on warn pin");

endmodule

// *** logic/acdp_pkg.sv ***
// constants, register map and carrier types of the ac diagnostic and protection block
package acdp_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_BRIDGE   = 8'h00;
	localparam logic [7:0] REG_MISC1    = 8'h01;
	localparam logic [7:0] REG_CH_STATE = 8'h0F;
	localparam logic [7:0] REG_FAULT    = 8'h10;
	localparam logic [7:0] REG_WARN     = 8'h13;
	localparam logic [7:0] REG_AC_EN    = 8'h15;
	localparam logic [7:0] REG_AC_CFG   = 8'h16;
	localparam logic [7:0] REG_PH_HI    = 8'h1B;
	localparam logic [7:0] REG_PH_LO    = 8'h1C;
	localparam logic [7:0] REG_STI_HI   = 8'h1D;
	localparam logic [7:0] REG_STI_LO   = 8'h1E;
	localparam logic [7:0] REG_MISC3    = 8'h21;
	localparam logic [7:0] REG_CLIP_WIN = 8'h23;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_PB_FIRST    = 0;
	localparam int BIT_PB_SECOND   = 1;
	localparam int BIT_ILIM_LVL    = 4;
	localparam int BIT_AC_LOOP1    = 3;
	localparam int BIT_AC_LOOP3    = 1;
	localparam int BIT_LOOPBACK    = 7;
	localparam int BIT_CLEAR_FAULT = 7;
	localparam int BIT_DC_MASK     = 0;
	localparam int BIT_CLIP_MASK   = 1;
	localparam int BIT_DIAG_EN     = 2;

	// ----------------------------------------
	// reset values and sizes
	// ----------------------------------------
	localparam logic [7:0] RST_CLIP_WIN = 8'h14;
	localparam logic       RST_DIAG_EN  = 1'b1;
	localparam int         NCH          = 4;
	localparam int         NSYNC        = 14;

	// reported channel codes
	localparam logic [1:0] CODE_PLAY = 2'h0;
	localparam logic [1:0] CODE_HIZ  = 2'h1;
	localparam logic [1:0] CODE_AC   = 2'h2;
	localparam logic [1:0] CODE_DC   = 2'h3;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		CH_PLAY = 4'h1,
		CH_HIZ  = 4'h2,
		CH_AC   = 4'h4,
		CH_DC   = 4'h8
	} acdp_ch_t;

	typedef enum logic [4:0] {
		I2_IDLE = 5'h01,
		I2_DEV  = 5'h02,
		I2_PTR  = 5'h04,
		I2_WR   = 5'h08,
		I2_RD   = 5'h10
	} acdp_i2c_t;

	typedef struct packed {
		logic [3:0] lim;
		logic [3:0] sd;
		logic [3:0] dc;
	} acdp_ana_t;

	typedef struct packed {
		logic        done;
		logic [15:0] phase;
		logic [15:0] stim;
	} acdp_ac_res_t;

endpackage

// *** verif/acdp_host.sv ***
// host controller model driving the block's control-bus pins
module acdp_host #(
	parameter logic [6:0] DEV_ADDR = 7'h5C // arbitrary value
) (
	// clock
	input  wire logic core_clk,
	// bus
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------
	// bit level
	// ------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// phases twice the minimum so the two sync flops never race
	task automatic bit_io(input logic b, output logic r);
		hold(1);
		sda_low <= !b;
		hold(6);
		scl <= 1'b1;
		hold(8);
		r = sda_line;
		scl <= 1'b0;
		hold(4);
	endtask
	task automatic start_c();
		hold(1);
		sda_low <= 1'b0;
		hold(4);
		scl <= 1'b1;
		hold(8);
		sda_low <= 1'b1;
		hold(8);
		scl <= 1'b0;
		hold(4);
	endtask
	task automatic stop_c();
		hold(1);
		sda_low <= 1'b1;
		hold(4);
		scl <= 1'b1;
		hold(8);
		sda_low <= 1'b0;
		hold(8);
	endtask
	// phase in degrees from loopback, load and stimulus readings
	function automatic int phase_deg(input logic [15:0] loopback_phase, input logic [15:0] load_phase, input logic [15:0] stimulus_count_high);
		return (360 * (int'(loopback_phase) - int'(load_phase))) / int'(stimulus_count_high);
	endfunction
	// impedance code to ohms per gain and current setting
	function automatic real imp_ohm(input int code, input logic gain4, input logic i19);
		real s;
		s = gain4 ? (i19 ? 0.0307 : 0.05832) : (i19 ? 0.1314 : 0.2496);
		return code * s;
	endfunction
	task automatic put(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ok = ok & !r;
	endtask
	// ------------
	// transactions
	// ------------
	// strictly one transaction at a time
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
		ok = 1'b1;
		start_c();
		put({dev, 1'b0}, ok);
		put(a, ok);
		put(d, ok);
		stop_c();
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic r;
		ok = 1'b1;
		start_c();
		put({DEV_ADDR, 1'b0}, ok);
		put(a, ok);
		start_c();
		put({DEV_ADDR, 1'b1}, ok);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		// nack ends the read
		bit_io(1'b1, r);
		stop_c();
	endtask
endmodule

// *** verif/test_amp_ac_diag_and_protection.sv ***
// self-checking bench of the ac diagnostic and protection core
module test_amp_ac_diag_and_protection;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdat;
		logic [7:0] rexp;
	} acdp_row_t;
	// ------------
	// signals
	// ------------
	logic                   core_clk = 1'b0;
	logic                   reset_n = 1'b0;
	logic                   scl_pin;
	logic                   host_sda_low;
	logic                   sda_pin_oe;
	logic                   fault_pin_oe;
	logic                   warn_pin_oe;
	acdp_pkg::acdp_ana_t    ana_in = '0;
	logic [3:0]             pwm_in = 4'hF; // full-scale drive
	logic                   pwm_tick = 1'b0;
	logic [3:0]             full_duty = 4'h0;
	logic [3:0]             pwm_out;
	acdp_pkg::acdp_ac_res_t ac_res = '0;
	logic [1:0]             ac_loop_run;
	logic                   ac_loopback_select;
	logic [3:0]             diag_done = 4'h0;
	logic [3:0]             load_fault = 4'h0;
	logic [3:0]             dc_diag_run;
	logic [1:0]             paired_bridge_mode;
	logic                   ilimit_level;
	logic [3:0]             chan_hiz;
	int                     failures = 0;
	int                     total_checks = 0;
	int                     cycles = 0;
	wire                    sda_line = !(host_sda_low | sda_pin_oe);
	localparam acdp_row_t ROWS [6] = '{
		'{acdp_pkg::REG_BRIDGE, 8'h03, 8'h03},
		'{acdp_pkg::REG_MISC1, 8'h10, 8'h10},
		'{acdp_pkg::REG_CLIP_WIN, 8'h05, 8'h05},
		'{acdp_pkg::REG_MISC3, 8'h86, 8'h06},
		'{acdp_pkg::REG_AC_CFG, 8'h80, 8'h80},
		'{8'h40, 8'hFF, 8'h00}
	};
	always #10 core_clk = !core_clk;
	acdp_core u_dut (
		.core_clk(core_clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_pin_in(sda_line),
		.sda_pin_out(), .sda_pin_oe(sda_pin_oe), .fault_pin_out(), .fault_pin_oe(fault_pin_oe),
		.warn_pin_out(), .warn_pin_oe(warn_pin_oe), .ana_in(ana_in), .pwm_in(pwm_in),
		.pwm_tick(pwm_tick), .full_duty(full_duty), .pwm_out(pwm_out), .ac_res(ac_res),
		.ac_loop_run(ac_loop_run), .ac_loopback_select(ac_loopback_select), .diag_done(diag_done),
		.load_fault(load_fault), .dc_diag_run(dc_diag_run), .paired_bridge_mode(paired_bridge_mode),
		.ilimit_level(ilimit_level), .chan_hiz(chan_hiz)
	);
	acdp_host u_host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl_pin), .sda_low(host_sda_low));
	// ------------
	// tasks
	// ------------
	task automatic test_done();
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t pin got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_host.read_reg(a, d, ok);
		total_checks++;
		if (d !== exp || ok !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t reg %h got %h expected %h", $time, a, d, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		u_host.write_reg(7'h5C, a, d, ok);
		chk_pin({7'h0, ok}, 8'h01);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic ana_set(input logic [11:0] v);
		@(posedge core_clk);
		ana_in <= acdp_pkg::acdp_ana_t'(v);
		wait_n(5);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge core_clk);
			pwm_tick <= 1'b1;
			@(posedge core_clk);
			pwm_tick <= 1'b0;
		end
		wait_n(3);
	endtask
	task automatic diag_pulse(input logic [3:0] f);
		@(posedge core_clk);
		diag_done <= 4'h4;
		load_fault <= f;
		@(posedge core_clk);
		diag_done <= 4'h0;
		load_fault <= 4'h0;
		wait_n(3);
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		wait_n(10);
		chk_pin({fault_pin_oe, warn_pin_oe, sda_pin_oe, 3'h0, ac_loop_run}, 8'h00);
		chk_pin({chan_hiz, dc_diag_run}, 8'h00);
		chk_pin({4'h0, pwm_out}, 8'h0F);
		chk_reg(acdp_pkg::REG_CLIP_WIN, acdp_pkg::RST_CLIP_WIN);
		chk_reg(acdp_pkg::REG_MISC3, 8'h04);
	endtask
	// reference stage when lb is 1, load stage otherwise
	task automatic ac_stage(input logic lb, input logic lp, input logic [15:0] ph, input logic [15:0] st);
		logic [7:0] st_ac;
		st_ac = lp ? 8'hA0 : 8'h0A;
		wr(acdp_pkg::REG_AC_CFG, {lb, 7'h00}); // select before enable
		chk_pin({7'h0, ac_loopback_select}, {7'h0, lb});
		wr(acdp_pkg::REG_AC_EN, lp ? 8'h02 : 8'h08);
		chk_pin({6'h0, ac_loop_run}, lp ? 8'h02 : 8'h01);
		chk_pin({4'h0, chan_hiz}, lp ? 8'h0C : 8'h03);
		chk_reg(acdp_pkg::REG_CH_STATE, st_ac);
		@(posedge core_clk);
		ac_res <= '{done: 1'b1, phase: ph, stim: st};
		@(posedge core_clk);
		ac_res.done <= 1'b0;
		wait_n(3);
		chk_pin({6'h0, ac_loop_run}, 8'h00);
		chk_reg(acdp_pkg::REG_CH_STATE, st_ac >> 1);
		chk_reg(acdp_pkg::REG_PH_HI, ph[15:8]);
		chk_reg(acdp_pkg::REG_PH_LO, ph[7:0]);
		if (!lb) begin
			chk_reg(acdp_pkg::REG_STI_HI, st[15:8]);
			chk_reg(acdp_pkg::REG_STI_LO, st[7:0]);
		end
		wr(acdp_pkg::REG_AC_EN, 8'h00); // enable back to zero
		chk_reg(acdp_pkg::REG_CH_STATE, 8'h00);
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			test_done();
		end
	end
	// ------------
	// main sequence
	// ------------
	initial begin
		do_reset();
		foreach (ROWS[i]) begin
			wr(ROWS[i].addr, ROWS[i].wdat);
			chk_reg(ROWS[i].addr, ROWS[i].rexp);
		end
		chk_pin({5'h0, paired_bridge_mode, ilimit_level}, 8'h07);
		wr(acdp_pkg::REG_BRIDGE, 8'h00); // bridge-tied for diagnostics
		chk_pin({6'h0, paired_bridge_mode}, 8'h00);
		ac_stage(1'b1, 1'b0, 16'h1234, 16'hFFFF);
		ac_stage(1'b1, 1'b1, 16'hA55A, 16'hFFFF);
		ac_stage(1'b0, 1'b1, 16'h0F01, 16'h8421);
		chk_pin(8'(u_host.phase_deg(16'h0100, 16'h00C0, 16'h0200)), 8'h2D);
		chk_pin(8'(int'(u_host.imp_ohm(200, 1'b1, 1'b0))), 8'h0C);
		wr(acdp_pkg::REG_BRIDGE, 8'h03);
		chk_pin({6'h0, paired_bridge_mode}, 8'h03);
		wr(acdp_pkg::REG_AC_EN, 8'h02);
		wr(acdp_pkg::REG_AC_EN, 8'h0A);
		chk_pin({6'h0, ac_loop_run}, 8'h02); // second start refused
		wr(acdp_pkg::REG_AC_EN, 8'h00);
		chk_pin({6'h0, ac_loop_run}, 8'h00);
		wr(acdp_pkg::REG_MISC3, 8'h04);
		ana_set(12'h300);
		chk_pin({fault_pin_oe, 3'h0, pwm_out}, 8'h0C); // pulse cut, no fault
		@(posedge core_clk);
		pwm_in <= 4'hE; // channel 0 pulse ends, releasing its cut
		ana_set(12'h040);
		@(posedge core_clk);
		pwm_in <= 4'hF;
		ana_set(12'h000);
		chk_pin({fault_pin_oe, pwm_out[2], 1'h0, pwm_out[0], chan_hiz}, 8'h94);
		chk_reg(acdp_pkg::REG_FAULT, 8'h04);
		wr(acdp_pkg::REG_MISC3, 8'h84);
		diag_pulse(4'h4);
		chk_pin({fault_pin_oe, 3'h0, dc_diag_run}, 8'h04); // rerun while load fails
		diag_pulse(4'h0);
		chk_pin({dc_diag_run, chan_hiz}, 8'h00);
		wr(acdp_pkg::REG_MISC3, 8'h00);
		ana_set(12'h020);
		ana_set(12'h000);
		chk_pin({fault_pin_oe, 3'h0, chan_hiz}, 8'h82);
		wr(acdp_pkg::REG_MISC3, 8'h80);
		chk_pin({dc_diag_run, chan_hiz}, 8'h00);
		wr(acdp_pkg::REG_MISC3, 8'h01);
		ana_set(12'h008);
		ana_set(12'h000);
		chk_pin({fault_pin_oe, 3'h0, chan_hiz}, 8'h08); // pin masked
		chk_reg(acdp_pkg::REG_FAULT, 8'h80);
		wr(acdp_pkg::REG_MISC3, 8'h00);
		@(posedge core_clk);
		full_duty <= 4'h2;
		ticks(4);
		chk_pin({7'h0, warn_pin_oe}, 8'h00); // one short of the window
		ticks(1);
		chk_pin({7'h0, warn_pin_oe}, 8'h01);
		@(posedge core_clk);
		full_duty <= 4'h0;
		ticks(2);
		chk_pin({7'h0, warn_pin_oe}, 8'h01); // latched
		chk_reg(acdp_pkg::REG_WARN, 8'h01);
		wr(acdp_pkg::REG_MISC3, 8'h80);
		chk_pin({7'h0, warn_pin_oe}, 8'h00);
		wr(acdp_pkg::REG_MISC3, 8'h02);
		@(posedge core_clk);
		full_duty <= 4'h2;
		ticks(5);
		chk_pin({7'h0, warn_pin_oe}, 8'h00); // masked pin
		chk_reg(acdp_pkg::REG_WARN, 8'h01);
		do_reset();
		test_done();
	end
endmodule
